// >>> hdl/sac_bit_clock.sv
// divider giving the conversion bit period enable pulse
`timescale 1ns/10ps
`default_nettype none
module sac_bit_clock
    import sac_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // control
    input wire logic run_in,
    input wire logic [1:0] sel_in,
    // enable pulse
    output logic tick_out
);
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;
    logic [6:0] limit;

    function automatic logic [6:0] div_of(input logic [1:0] s);
        case (s)
            2'h0: div_of = 7'(SAC_DIV_SLOW0 - 1);
            2'h1: div_of = 7'(SAC_DIV_SLOW1 - 1);
            2'h2: div_of = 7'(SAC_DIV_SLOW2 - 1);
            default: div_of = 7'(SAC_DIV_RC - 1);
        endcase
    endfunction

    always_comb
    begin
        limit = div_of(sel_in);
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!run_in)
        begin
            cnt_nxt = 7'h00;
        end
        else if (cnt_r >= limit)
        begin
            cnt_nxt = 7'h00;
            tick_nxt = 1'b1;
        end
        else
        begin
            cnt_nxt = cnt_r + 7'h01;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_r <= 7'h00;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_out = tick_r;
endmodule
`default_nettype wire

// >>> hdl/sac_control.sv
// successive approximation converter control with register port
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module sac_control
    import sac_pkg::*;
#(
    parameter int CHANNELS = 16
)
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // converter core
    input wire logic cmp_in,
    output logic [3:0] channel_out,
    output logic ref_pins_out,
    output logic power_on_out,
    output logic hold_out,
    output logic [9:0] trial_out,
    output logic [2:0] pin_config_out,
    // interrupt
    output logic irq_out
);
    // only the two channel counts below have a select decoder
    if (CHANNELS != 12 && CHANNELS != 16)
    begin
        $error("channel count must be 12 or 16");
    end

    sac_bus_t bus;
    sac_analog_t ana;
    logic cmp_meta_r;
    logic cmp_sync_r;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic stat_r, stat_nxt;
    logic [9:0] res_r, res_nxt;
    logic [9:0] sar_r, sar_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [1:0] wait_r, wait_nxt;
    sac_state_t state_r, state_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    sac_analog_t ana_r;
    logic irq_r;
    logic tick;
    logic done;
    logic [7:0] ctrl_w;

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // comparator comes from the analog core, synchronise first
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end
        else
        begin
            cmp_meta_r <= cmp_in;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // bit period divider, counts core clocks up to the divisor picked by the clock select field
    sac_bit_clock u_bit_clock (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .run_in(state_r != SAC_IDLE),
        .sel_in(cfg_r[SAC_CLKSEL_LSB +: 2]),
        .tick_out(tick)
    );

    // register index decode shared by the write and read paths
    function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
        hit = (a == idx);
    endfunction

    function automatic logic [7:0] result_byte(input logic [9:0] r, input logic right,
                                               input logic high);
        logic [15:0] w;
        w = right ? {6'h00, r} : {r, 6'h00};
        result_byte = high ? w[15:8] : w[7:0];
    endfunction

    // register writes, sequence and read data
    always_comb
    begin
        ctrl_w = (bus.wdata & SAC_CTRL_WMASK);
        if (CHANNELS == 12 && ctrl_w[7:6] == 2'b11)
        begin
            ctrl_w[7:6] = 2'b10; // reserved codes kept in range
        end
        ctrl_nxt = ctrl_r;
        cfg_nxt = cfg_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        res_nxt = res_r;
        sar_nxt = sar_r;
        bit_nxt = bit_r;
        wait_nxt = wait_r;
        state_nxt = state_r;
        done = 1'b0;
        rdata_nxt = 8'h00;
        if (bus.wr && hit(bus.addr, {1'b0, SAC_OFF_CTRL}))
        begin
            ctrl_nxt = ctrl_w;
            if (!ctrl_w[SAC_EN_BIT])
            begin
                ctrl_nxt[SAC_GO_BIT] = 1'b0;
            end
        end
        else if (bus.wr && hit(bus.addr, {1'b0, SAC_OFF_CFG}))
        begin
            cfg_nxt = bus.wdata & SAC_CFG_WMASK;
        end
        else if (bus.wr && hit(bus.addr, SAC_OFF_IRQ_MASK))
        begin
            mask_nxt = {7'h00, bus.wdata[0]};
        end
        case (state_r)
            SAC_IDLE:
            begin
                if (ctrl_r[SAC_GO_BIT] && ctrl_r[SAC_EN_BIT])
                begin
                    state_nxt = SAC_SAMPLE;
                    wait_nxt = 2'(SAC_ACQ_PERIODS - 1);
                end
            end
            SAC_SAMPLE:
            begin
                if (tick)
                begin
                    if (wait_r == 2'h0)
                    begin
                        state_nxt = SAC_CONVERT;
                        sar_nxt = 10'h200;
                        bit_nxt = 4'(SAC_RES_BITS - 1);
                    end
                    else
                    begin
                        wait_nxt = wait_r - 2'h1;
                    end
                end
            end
            SAC_CONVERT:
            begin
                if (tick)
                begin
                    if (!cmp_sync_r)
                    begin
                        sar_nxt[bit_r] = 1'b0;
                    end
                    if (bit_r == 4'h0)
                    begin
                        done = 1'b1;
                        res_nxt = cmp_sync_r ? sar_r : (sar_r & ~10'h001);
                        state_nxt = SAC_GAP;
                        wait_nxt = 2'(SAC_GAP_PERIODS - 1);
                    end
                    else
                    begin
                        sar_nxt[bit_r - 4'h1] = 1'b1;
                        bit_nxt = bit_r - 4'h1;
                    end
                end
            end
            default:
            begin
                if (tick)
                begin
                    if (wait_r == 2'h0)
                    begin
                        state_nxt = SAC_IDLE;
                    end
                    else
                    begin
                        wait_nxt = wait_r - 2'h1;
                    end
                end
            end
        endcase
        if (!ctrl_nxt[SAC_EN_BIT])
        begin
            state_nxt = SAC_IDLE;
        end
        if (done)
        begin
            ctrl_nxt[SAC_GO_BIT] = 1'b0;
        end
        if (bus.rd)
        begin
            if (hit(bus.addr, {1'b0, SAC_OFF_RES_HIGH}))
            begin
                rdata_nxt = result_byte(res_r, cfg_r[SAC_JUSTIFY_BIT], 1'b1);
            end
            else if (hit(bus.addr, {1'b0, SAC_OFF_RES_LOW}))
            begin
                rdata_nxt = result_byte(res_r, cfg_r[SAC_JUSTIFY_BIT], 1'b0);
            end
            else if (hit(bus.addr, {1'b0, SAC_OFF_CTRL}))
            begin
                rdata_nxt = ctrl_r;
            end
            else if (hit(bus.addr, {1'b0, SAC_OFF_CFG}))
            begin
                rdata_nxt = cfg_r;
            end
            else if (hit(bus.addr, SAC_OFF_IRQ_STAT))
            begin
                rdata_nxt = {7'h00, stat_r};
                stat_nxt = 1'b0;
            end
            else if (hit(bus.addr, SAC_OFF_IRQ_MASK))
            begin
                rdata_nxt = mask_r;
            end
        end
        if (done)
        begin
            stat_nxt = 1'b1; // set beats read clear
        end
        ana.channel = ctrl_nxt[SAC_CHS_LSB +: 4];
        ana.ref_pins = cfg_nxt[SAC_REFSEL_BIT];
        ana.power_on = ctrl_nxt[SAC_EN_BIT];
        ana.hold = (state_nxt == SAC_CONVERT);
        ana.trial = sar_nxt;
    end

    // all state runs on the core clock, kept alive in sleep
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctrl_r <= SAC_CTRL_RST;
            cfg_r <= SAC_CFG_RST;
            mask_r <= SAC_MASK_RST;
            stat_r <= 1'b0;
            res_r <= 10'h000;
            sar_r <= 10'h000;
            bit_r <= 4'h0;
            wait_r <= 2'h0;
            state_r <= SAC_IDLE;
            rdata_r <= 8'h00;
            ana_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            cfg_r <= cfg_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            res_r <= res_nxt;
            sar_r <= sar_nxt;
            bit_r <= bit_nxt;
            wait_r <= wait_nxt;
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
            ana_r <= ana;
            irq_r <= stat_nxt & mask_nxt[0];
        end
    end

    assign rdata_out = rdata_r;
    assign channel_out = ana_r.channel;
    assign ref_pins_out = ana_r.ref_pins;
    assign power_on_out = ana_r.power_on;
    assign hold_out = ana_r.hold;
    assign trial_out = ana_r.trial;
    assign pin_config_out = cfg_r[3:1];
    assign irq_out = irq_r;
endmodule
`default_nettype wire

// >>> hdl/sac_pkg.sv
// package for the successive approximation converter control block
package sac_pkg;
    // register indices on the local port
    localparam logic [1:0] SAC_OFF_RES_HIGH = 2'h0;
    localparam logic [1:0] SAC_OFF_RES_LOW = 2'h1;
    localparam logic [1:0] SAC_OFF_CTRL = 2'h2;
    localparam logic [1:0] SAC_OFF_CFG = 2'h3;
    localparam logic [2:0] SAC_OFF_IRQ_STAT = 3'h4;
    localparam logic [2:0] SAC_OFF_IRQ_MASK = 3'h5;
    // control register fields
    localparam int SAC_CHS_LSB = 4;
    localparam int SAC_GO_BIT = 2;
    localparam int SAC_EN_BIT = 0;
    localparam logic [7:0] SAC_CTRL_WMASK = 8'hF5;
    localparam logic [7:0] SAC_CTRL_RST = 8'h00;
    // configuration register fields
    localparam int SAC_CLKSEL_LSB = 6;
    localparam int SAC_JUSTIFY_BIT = 5;
    localparam int SAC_REFSEL_BIT = 0;
    localparam logic [7:0] SAC_CFG_WMASK = 8'hEF;
    localparam logic [7:0] SAC_CFG_RST = 8'h00;
    localparam logic [7:0] SAC_MASK_RST = 8'h00;
    // conversion timing, in conversion bit periods
    localparam int SAC_RES_BITS = 10;
    localparam int SAC_ACQ_PERIODS = 2;
    localparam int SAC_GAP_PERIODS = 2;
    // system clock divisors and internal rc rate in system clocks
    localparam int SAC_DIV_SLOW0 = 8;
    localparam int SAC_DIV_SLOW1 = 32;
    localparam int SAC_DIV_SLOW2 = 64;
    localparam int SAC_DIV_RC = 40;
    // states of the converter sequence
    typedef enum logic [2:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_CONVERT,
        SAC_GAP
    } sac_state_t;
    // register access bundle
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sac_bus_t;
    // analog side command bundle
    typedef struct packed {
        logic [3:0] channel;
        logic ref_pins;
        logic power_on;
        logic hold;
        logic [9:0] trial;
    } sac_analog_t;
endpackage

// >>> sim/sac_analog_model.sv
// sample and hold plus comparator model of the analog side
`timescale 1ns/10ps
`default_nettype none
module sac_analog_model
(
    // clock
    input wire logic core_clk_in,
    // analog side
    input wire logic [9:0] level_in,
    input wire logic hold_in,
    input wire logic power_on_in,
    input wire logic [9:0] trial_in,
    output logic cmp_out
);
    logic [9:0] held_r;
    logic tog_r = 1'b0;
    always @(posedge hold_in) held_r <= level_in;
    always @(posedge core_clk_in) tog_r <= ~tog_r;
    // outside a conversion the comparator output is meaningless
    assign cmp_out = (hold_in && power_on_in) ? (held_r >= trial_in) : tog_r;
endmodule
`default_nettype wire

// >>> sim/sac_control_properties.sv
// concurrent checks on the converter control block ports
`timescale 1ns/10ps
`default_nettype none
module sac_control_properties
    import sac_pkg::*;
#(
    parameter int CHANNELS = 16
)
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // converter core
    input wire logic cmp_in,
    input wire logic [3:0] channel_out,
    input wire logic ref_pins_out,
    input wire logic power_on_out,
    input wire logic hold_out,
    input wire logic [9:0] trial_out,
    input wire logic [2:0] pin_config_out,
    // interrupt
    input wire logic irq_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    read_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside a read cycle");
    unmapped_read_a: assert property (rd_in && addr_in > 3'h5 |=> rdata_out == 8'h00)
        else $error("unmapped index read nonzero");
    ctrl_zero_bits_a: assert property (rd_in && addr_in == 3'h2 |=> !rdata_out[3] && !rdata_out[1])
        else $error("unused control bits read nonzero");
    channel_follow_a: assert property (wr_in && addr_in == 3'h2 |=>
        channel_out == ((CHANNELS == 12 && $past(wdata_in[7:6]) == 2'b11) ?
        {2'b10, $past(wdata_in[5:4])} : $past(wdata_in[7:4])))
        else $error("channel output differs from written code");
    enable_follow_a: assert property (wr_in && addr_in == 3'h2 |=> power_on_out == $past(wdata_in[0]))
        else $error("enable output differs from written bit");
    ref_select_a: assert property (wr_in && addr_in == 3'h3 |=> ref_pins_out == $past(wdata_in[0]))
        else $error("reference select differs from written bit");
    pin_config_a: assert property (wr_in && addr_in == 3'h3 |=> pin_config_out == $past(wdata_in[3:1]))
        else $error("pin configuration differs from written field");
    no_start_off_a: assert property (wr_in && addr_in == 3'h2 && !wdata_in[0] |=> ##1 !hold_out [*8])
        else $error("conversion started while disabled");
    irq_clear_a: assert property (rd_in && addr_in == 3'h4 && !hold_out |=> ##1 !irq_out)
        else $error("interrupt stays after status read");
    off_no_hold_a: assert property (!power_on_out |-> !hold_out)
        else $error("converter holds while switched off");
    first_trial_a: assert property ($rose(hold_out) |-> trial_out == 10'h200)
        else $error("first trial word is not the midpoint");
endmodule
bind sac_control sac_control_properties #(.CHANNELS(CHANNELS)) u_props (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .cmp_in(cmp_in), .channel_out(channel_out),
    .ref_pins_out(ref_pins_out), .power_on_out(power_on_out), .hold_out(hold_out),
    .trial_out(trial_out), .pin_config_out(pin_config_out), .irq_out(irq_out));
`default_nettype wire

// >>> sim/sac_control_test.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module sac_control_test;
    import sac_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr_r = 3'h0;
    logic [7:0] wdata_r = 8'h00;
    logic wr_r = 1'b0;
    logic rd_r = 1'b0;
    logic [9:0] level_r = 10'h000;
    logic cmp, hold, pwr, refp, irq;
    logic [7:0] rdata, d, cfg;
    logic [3:0] chan;
    logic [9:0] trial;
    logic [2:0] pcfg;
    int miscompares = 0;
    int cmp_count = 0;
    int lvl, ch, dv;
    initial forever #25 clk = ~clk;
    sac_control u_sac_control (.core_clk_in(clk), .rst_in(rst), .addr_in(addr_r),
        .wdata_in(wdata_r), .wr_in(wr_r), .rd_in(rd_r), .rdata_out(rdata), .cmp_in(cmp),
        .channel_out(chan), .ref_pins_out(refp), .power_on_out(pwr), .hold_out(hold),
        .trial_out(trial), .pin_config_out(pcfg), .irq_out(irq));
    sac_analog_model u_sac_analog_model (.core_clk_in(clk), .level_in(level_r),
        .hold_in(hold), .power_on_in(pwr), .trial_in(trial), .cmp_out(cmp));
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr_r <= a;
        wdata_r <= v;
        wr_r <= 1'b1;
        @(posedge clk);
        wr_r <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr_r <= a;
        rd_r <= 1'b1;
        @(posedge clk);
        rd_r <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(10'(v), 10'(e));
    endtask
    task automatic conclude();
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        conclude();
    end
    initial
    begin
        void'($urandom(5776));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rc(3'h2, 8'h00);
        rc(3'h3, 8'h00);
        rc(3'h5, 8'h00);
        rc(3'h6, 8'h00);
        wr(3'h2, 8'hFE);
        rc(3'h2, 8'hF0);
        repeat (40) @(posedge clk);
        #1 chk(10'(hold), 10'h0);
        wr(3'h3, 8'hFF);
        rc(3'h3, 8'hEF);
        for (int i = 0; i < 4; i++)
        begin
            lvl = $urandom % 1024;
            ch = $urandom % 16;
            dv = i[1] ? (i[0] ? SAC_DIV_RC : SAC_DIV_SLOW2) :
                (i[0] ? SAC_DIV_SLOW1 : SAC_DIV_SLOW0);
            cfg = {2'(i), i[0], 1'b0, 3'($urandom), i[1]};
            level_r <= 10'(lvl);
            wr(3'h3, cfg);
            wr(3'h5, {7'h00, i != 3});
            wr(3'h2, {4'(ch), 4'h1});
            wr(3'h2, {4'(ch), 4'h5});
            for (int k = 0; k < 600; k++)
            begin
                rd(3'h2, d);
                if (hold === 1'b1)
                    level_r <= ~10'(lvl);
                if (d[2] === 1'b0)
                    break;
            end
            chk(10'(d), 10'({4'(ch), 4'h1}));
            repeat (2) @(posedge clk);
            #1 chk(10'(irq), 10'(i != 3));
            chk({chan, pwr, refp, pcfg, 1'b0}, {4'(ch), 1'b1, cfg[0], cfg[3:1], 1'b0});
            rc(3'h0, i[0] ? 8'(lvl >> 8) : 8'(lvl >> 2));
            rc(3'h1, i[0] ? 8'(lvl) : 8'(lvl << 6));
            rc(3'h4, 8'h01);
            rc(3'h4, 8'h00);
            chk(10'(irq), 10'h0);
            repeat (2 * dv) @(posedge clk);
        end
        conclude();
    end
endmodule
`default_nettype wire
